//--- sdw_pkg.sv
// What this block does
// - Load held low: update on sixteenth falling edge
// - Host sends sixteen bits per frame
// - Host data valid at device falling edge
// - Rising-edge host inverts clock before the device; this host drives sclk_reg to the pin uninverted
// - Frame select active low, host inverts pulse
// - Standard mode: bit order high, alignment low
// - Order low, alignment high: LSB first
// - External load strobe updates; timed after transfer
// - Chip-select/serial-mode level picks serial operation
// - Serial mode pin low, parallel bus idle
package sdw_pkg;
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 14;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'hf;

    localparam int CLK_HZ = 25_000_000;
    localparam int SCLK_MAX_HZ = 6_000_000;
    // Least half period rounds up so the link never beats its top rate
    localparam int SCLK_HALF = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF - 1);
    localparam logic [3:0] LOAD_PERIODS_LAST = 4'h3;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_STROBE = 8'h0c;
    localparam logic [7:0] OFS_FRAMES = 8'h10;

    localparam int CTRL_AUTO_LOAD = 0;
    localparam int CTRL_LSB_FIRST = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PENDING = 1;
    localparam int STAT_LOADING = 2;
    localparam int STROBE_GO = 0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {SDW_IDLE, SDW_SHIFT, SDW_LOAD} sdw_state_t;

    // Alignment low: code in the upper bits; high: code in the lower bits
    function automatic logic [CODE_BITS-1:0] sdw_extract(input logic [WORD_BITS-1:0] w,
                                                         input logic align_low_bits);
        sdw_extract = align_low_bits ? w[CODE_BITS-1:0] : w[WORD_BITS-1:WORD_BITS-CODE_BITS];
    endfunction : sdw_extract

    function automatic logic [WORD_BITS-1:0] sdw_pack(input logic [CODE_BITS-1:0] c,
                                                      input logic align_low_bits);
        sdw_pack = align_low_bits ? {2'h0, c} : {c, 2'h0};
    endfunction : sdw_pack
endpackage : sdw_pkg

//--- sdw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdw_link_if;
    logic sclk;
    logic frame_n;
    logic sdata;
    logic converter_latch_load_n;
    logic bit_order_select;
    logic word_alignment_select;
    logic serial_mode_n;

    modport host (
        output sclk,
        output frame_n,
        output sdata,
        output converter_latch_load_n,
        output bit_order_select,
        output word_alignment_select,
        output serial_mode_n
    );
    modport device (
        input sclk,
        input frame_n,
        input sdata,
        input converter_latch_load_n,
        input bit_order_select,
        input word_alignment_select,
        input serial_mode_n
    );
endinterface : sdw_link_if
`default_nettype wire

//--- sdw_device.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_device import sdw_pkg::*; (
    sdw_link_if.device link,
    input wire logic reset_n_in,
    output logic [CODE_BITS-1:0] input_latch_out,
    output logic [CODE_BITS-1:0] dac_code_out,
    output logic word_done_out
);
    // Everything here runs on the link clock's falling edge, where data is taken
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] shift_next;
    logic lsb_first;
    logic align_low;
    logic load_n;
    logic serial_sel;
    logic active;
    logic word_done;

    // Load strobe and strap pins are asynchronous to the link clock
    always_ff @(negedge link.sclk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_meta_reg <= 4'hf;
            pin_sync_reg <= 4'hf;
        end else begin
            pin_meta_reg <= {link.serial_mode_n, link.converter_latch_load_n,
                             link.word_alignment_select, link.bit_order_select};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign lsb_first = ~pin_sync_reg[0];
    assign align_low = pin_sync_reg[1];
    assign load_n = pin_sync_reg[2];
    assign serial_sel = ~pin_sync_reg[3];
    assign active = serial_sel && !link.frame_n;
    assign word_done = active && (bit_cnt_reg == LAST_BIT);
    assign shift_next = lsb_first ? {link.sdata, shift_reg[WORD_BITS-1:1]}
                                  : {shift_reg[WORD_BITS-2:0], link.sdata};

    always_ff @(negedge link.sclk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bit_cnt_reg <= '0;
        end else if (!active) begin
            bit_cnt_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(negedge link.sclk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_reg <= '0;
        end else if (active) begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(negedge link.sclk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            input_latch_out <= '0;
            word_done_out <= 1'b0;
        end else begin
            word_done_out <= word_done;
            if (word_done) begin
                input_latch_out <= sdw_extract(shift_next, align_low);
            end
        end
    end

    // Strobe low keeps the converter latch following the input latch
    always_ff @(negedge link.sclk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dac_code_out <= '0;
        end else if (!load_n) begin
            if (word_done) begin
                dac_code_out <= sdw_extract(shift_next, align_low);
            end else begin
                dac_code_out <= input_latch_out;
            end
        end
    end
endmodule : sdw_device
`default_nettype wire

//--- sdw_host.sv
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sdw_host import sdw_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    sdw_link_if.host link
);
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [1:0] ctrl_reg;
    logic [CODE_BITS-1:0] data_reg;
    logic pending_reg;
    logic strobe_req_reg;
    logic [15:0] frames_reg;
    logic [3:0] div_cnt_reg;
    logic sclk_reg;
    logic frame_n_reg;
    logic sdata_reg;
    logic load_n_reg;
    logic order_reg;
    logic align_reg;
    logic serial_n_reg;
    sdw_state_t state_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [3:0] load_cnt_reg;
    logic [WORD_BITS-1:0] word_reg;
    logic lsb_reg;
    logic addr_phase;
    logic div_tick;
    logic launch;
    logic take;
    logic bus_data_wr;
    logic bus_strobe_wr;
    logic [31:0] read_mux;
    logic [WORD_BITS-1:0] packed_word;

    assign addr_phase = hsel_in && hready_in && htrans_in[1];
    assign bus_data_wr = wr_pend_reg && (wr_addr_reg == OFS_DATA);
    assign bus_strobe_wr = wr_pend_reg && (wr_addr_reg == OFS_STROBE) && hwdata_in[STROBE_GO];
    assign div_tick = (div_cnt_reg == SCLK_HALF_LAST);
    // Data launches as the link clock rises, so it is settled at its fall
    assign launch = div_tick && !sclk_reg;
    assign take = launch && (state_reg == SDW_IDLE) && pending_reg;
    // Packed in the same sense as the straps now on the pins
    assign packed_word = sdw_pack(data_reg, lsb_reg);

    always_comb begin
        read_mux = 32'h0;
        case (haddr_in[7:0])
            OFS_CTRL: read_mux = {30'h0, ctrl_reg};
            OFS_DATA: read_mux = {18'h0, data_reg};
            OFS_STATUS: begin
                read_mux[STAT_BUSY] = (state_reg != SDW_IDLE);
                read_mux[STAT_PENDING] = pending_reg;
                read_mux[STAT_LOADING] = (state_reg == SDW_LOAD);
            end
            OFS_FRAMES: read_mux = {16'h0, frames_reg};
            default: read_mux = 32'h0;
        endcase
    end

    // Zero-wait slave: read data is caught in the address phase
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h0;
            hrdata_out <= 32'h0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite_in && (hsize_in == HSIZE_WORD);
            if (addr_phase) begin
                wr_addr_reg <= haddr_in[7:0];
                hrdata_out <= hwrite_in ? 32'h0 : read_mux;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_pend_reg && (wr_addr_reg == OFS_CTRL)) begin
            ctrl_reg <= hwdata_in[1:0];
        end
    end

    // A new word is refused while one still waits; software polls pending
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_reg <= '0;
            pending_reg <= 1'b0;
        end else if (bus_data_wr && !pending_reg) begin
            data_reg <= hwdata_in[CODE_BITS-1:0];
            pending_reg <= 1'b1;
        end else if (take) begin
            pending_reg <= 1'b0;
        end
    end

    // Request set wins over the clear when both land together
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strobe_req_reg <= 1'b0;
        end else if (bus_strobe_wr) begin
            strobe_req_reg <= 1'b1;
        end else if (launch && (state_reg == SDW_IDLE) && !pending_reg) begin
            strobe_req_reg <= 1'b0;
        end
    end

    // Link clock made by dividing clk_in; runs free so strobes are seen
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_cnt_reg <= 4'h0;
            sclk_reg <= 1'b0;
        end else if (div_tick) begin
            div_cnt_reg <= 4'h0;
            sclk_reg <= ~sclk_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
        end
    end

    // Serial mode is chosen from the first clock after reset; no parallel bus exists on this end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            serial_n_reg <= 1'b1;
        end else begin
            serial_n_reg <= 1'b0;
        end
    end

    // Straps change only between frames
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            order_reg <= 1'b1;
            align_reg <= 1'b0;
            lsb_reg <= 1'b0;
        end else if (state_reg == SDW_IDLE && !take) begin
            order_reg <= ~ctrl_reg[CTRL_LSB_FIRST];
            align_reg <= ctrl_reg[CTRL_LSB_FIRST];
            lsb_reg <= ctrl_reg[CTRL_LSB_FIRST];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= SDW_IDLE;
            bit_cnt_reg <= '0;
            load_cnt_reg <= 4'h0;
            word_reg <= '0;
            frame_n_reg <= 1'b1;
            sdata_reg <= 1'b0;
            load_n_reg <= 1'b1;
            frames_reg <= 16'h0;
        end else if (launch) begin
            case (state_reg)
                SDW_IDLE: begin
                    load_n_reg <= ~ctrl_reg[CTRL_AUTO_LOAD];
                    if (pending_reg) begin
                        word_reg <= packed_word;
                        bit_cnt_reg <= '0;
                        frame_n_reg <= 1'b0;
                        sdata_reg <= lsb_reg ? packed_word[0] : packed_word[WORD_BITS-1];
                        state_reg <= SDW_SHIFT;
                    end else if (strobe_req_reg && !ctrl_reg[CTRL_AUTO_LOAD]) begin
                        load_n_reg <= 1'b0;
                        load_cnt_reg <= 4'h0;
                        state_reg <= SDW_LOAD;
                    end
                end
                SDW_SHIFT: begin
                    if (bit_cnt_reg == LAST_BIT) begin
                        frame_n_reg <= 1'b1;
                        sdata_reg <= 1'b0;
                        frames_reg <= frames_reg + 16'h1;
                        if (ctrl_reg[CTRL_AUTO_LOAD]) begin
                            state_reg <= SDW_IDLE;
                        end else begin
                            load_n_reg <= 1'b0;
                            load_cnt_reg <= 4'h0;
                            state_reg <= SDW_LOAD;
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        sdata_reg <= lsb_reg ? word_reg[bit_cnt_reg + 4'h1]
                                             : word_reg[LAST_BIT - bit_cnt_reg - 4'h1];
                    end
                end
                SDW_LOAD: begin
                    if (load_cnt_reg == LOAD_PERIODS_LAST) begin
                        load_n_reg <= 1'b1;
                        state_reg <= SDW_IDLE;
                    end else begin
                        load_cnt_reg <= load_cnt_reg + 4'h1;
                    end
                end
                default: begin
                    state_reg <= SDW_IDLE;
                end
            endcase
        end
    end

    // Internal launch phase is the rising one; the pin carries it as is,
    // not in the inverted sense a rising-edge host must present
    assign link.sclk = sclk_reg;
    assign link.frame_n = frame_n_reg;
    assign link.sdata = sdata_reg;
    assign link.converter_latch_load_n = load_n_reg;
    assign link.bit_order_select = order_reg;
    assign link.word_alignment_select = align_reg;
    assign link.serial_mode_n = serial_n_reg;
endmodule : sdw_host
`default_nettype wire

//--- sdw_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_link_props (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic sclk,
    input wire logic frame_n,
    input wire logic sdata,
    input wire logic converter_latch_load_n,
    input wire logic bit_order_select,
    input wire logic word_alignment_select,
    input wire logic serial_mode_n
);
    logic [7:0] frame_low_reg;
    logic [7:0] load_low_reg;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            frame_low_reg <= 8'h00;
        end else begin
            frame_low_reg <= frame_n ? 8'h00 : frame_low_reg + 8'h01;
        end
    end

    // Saturates so a long auto-mode low never wraps into a legal width
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            load_low_reg <= 8'h00;
        end else if (converter_latch_load_n) begin
            load_low_reg <= 8'h00;
        end else if (load_low_reg != 8'hff) begin
            load_low_reg <= load_low_reg + 8'h01;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sclk_rate_a: assert property ($changed(sclk) |=>
        $stable(sclk) ##1 $stable(sclk) ##1 $changed(sclk)) else $error("link clock rate wrong");
    frame_len_a: assert property ($rose(frame_n) |-> frame_low_reg == 8'h60)
        else $error("frame not sixteen periods long");
    frame_gap_a: assert property ($rose(frame_n) |-> frame_n [*6])
        else $error("frame gap too short");
    data_setup_a: assert property ($fell(sclk) |-> $stable(sdata) && $stable(frame_n))
        else $error("data moves at sampling edge");
    load_width_a: assert property ($rose(converter_latch_load_n) && load_low_reg != 8'hff
        |-> load_low_reg == 8'h18) else $error("load pulse width wrong");
    load_after_a: assert property ($fell(converter_latch_load_n) |-> frame_n)
        else $error("load strobe inside frame");
    strap_pair_a: assert property (bit_order_select ^ word_alignment_select)
        else $error("straps not in a legal pair");
    strap_hold_a: assert property (!frame_n |-> $stable(bit_order_select)
        && $stable(word_alignment_select)) else $error("straps move in frame");
    serial_mode_a: assert property (1'b1 |=> !serial_mode_n)
        else $error("serial mode not selected");

    cover property ($rose(frame_n) && !bit_order_select);
    cover property ($fell(converter_latch_load_n));
    cover property ($rose(frame_n) && bit_order_select);
endmodule : sdw_link_props
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import sdw_pkg::*;;
    logic clk_in = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [13:0] dac_exp = 14'h0;
    logic [CODE_BITS-1:0] in_latch;
    logic [CODE_BITS-1:0] dac_code;
    logic word_done;
    logic [15:0] mon_w = 16'h0;
    logic [31:0] rd;
    logic [31:0] frames_exp = 32'h0;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #20 clk_in = ~clk_in;

    sdw_link_if link();
    sdw_host i_sdw_host (.clk_in(clk_in), .reset_n_in(reset_n), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .link(link));
    sdw_device i_sdw_device (.link(link), .reset_n_in(reset_n), .input_latch_out(in_latch),
        .dac_code_out(dac_code), .word_done_out(word_done));
    sdw_link_props i_sdw_link_props (.clk_in(clk_in), .reset_n_in(reset_n),
        .sclk(link.sclk), .frame_n(link.frame_n), .sdata(link.sdata),
        .converter_latch_load_n(link.converter_latch_load_n),
        .bit_order_select(link.bit_order_select),
        .word_alignment_select(link.word_alignment_select),
        .serial_mode_n(link.serial_mode_n));

    // Rebuilds the word off the wire, independent of the device
    always @(negedge link.sclk) begin
        if (!link.frame_n) begin
            mon_w <= link.bit_order_select ? {mon_w[14:0], link.sdata} : {link.sdata, mon_w[15:1]};
        end
    end

    task conclude;
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            conclude();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
        check({31'h0, hresp}, 32'h0);
    endtask : rd_chk

    // Status lags the write by a cycle, so let it settle before polling
    task wait_idle;
        int n;
        n = 0;
        repeat (2) @(posedge clk_in);
        do begin
            xfer(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd !== 32'h0 && n < 200);
        check(rd, 32'h0);
    endtask : wait_idle

    task wait_done;
        int n;
        n = 0;
        while (word_done !== 1'b1 && n < 400) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check({31'h0, word_done}, 32'h1);
    endtask : wait_done

    task send(input logic [13:0] c, input logic lsb, input logic auto);
        logic [15:0] w;
        w = lsb ? {2'h0, c} : {c, 2'h0};
        xfer(1'b1, OFS_DATA, {18'h0, c});
        wait_done();
        check({18'h0, in_latch}, {18'h0, c});
        check({16'h0, mon_w}, {16'h0, w});
        if (auto) begin
            check({18'h0, dac_code}, {18'h0, c});
        end else begin
            check({18'h0, dac_code}, {18'h0, dac_exp});
        end
        wait_idle();
        check({18'h0, dac_code}, {18'h0, c});
        dac_exp = c;
        frames_exp++;
    endtask : send

    // Straps pass two link-clock flops in the device; let them settle
    task set_mode(input logic [31:0] v);
        xfer(1'b1, OFS_CTRL, v);
        repeat (8 * SCLK_HALF) @(posedge clk_in);
    endtask : set_mode

    logic [13:0] codes [3] = '{14'h2a5c, 14'h3fff, 14'h0001};

    initial begin
        repeat (3) @(posedge clk_in);
        reset_n <= 1'b1;
        @(posedge clk_in);
        rd_chk(OFS_CTRL, {30'h0, CTRL_RESET});
        rd_chk(OFS_STATUS, 32'h0);
        rd_chk(OFS_FRAMES, 32'h0);
        rd_chk(8'h20, 32'h0);
        check({31'h0, link.bit_order_select}, 32'h1);
        check({31'h0, link.word_alignment_select}, 32'h0);
        check({31'h0, link.serial_mode_n}, 32'h0);
        foreach (codes[i]) send(codes[i], 1'b0, 1'b1);
        // Start just after a launch so the second word lands while one waits
        @(posedge link.sclk);
        xfer(1'b1, OFS_DATA, 32'h1234);
        xfer(1'b1, OFS_DATA, 32'h0f0f);
        wait_done();
        check({18'h0, in_latch}, 32'h1234);
        wait_idle();
        rd_chk(OFS_DATA, 32'h1234);
        dac_exp = 14'h1234;
        frames_exp++;
        set_mode(32'h3);
        foreach (codes[i]) send(codes[i], 1'b1, 1'b1);
        set_mode(32'h0);
        send(14'h1555, 1'b0, 1'b0);
        send(14'h2aaa, 1'b0, 1'b0);
        xfer(1'b1, OFS_STROBE, 32'h1);
        for (int n = 0; n < 100 && link.converter_latch_load_n !== 1'b0; n++) @(posedge clk_in);
        check({31'h0, link.converter_latch_load_n}, 32'h0);
        wait_idle();
        check({18'h0, dac_code}, 32'h2aaa);
        xfer(1'b1, 8'h20, 32'hffff_ffff);
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_FRAMES, frames_exp);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
